/* File: logic/cfr_pkg.sv */
// Operation
// [R1] Response code 10 turns the output off at once on an undercurrent fault and restarts it as the retry count allows.
// [R2] Response code 11 turns the output off at once and turns it back on by itself when the fault has gone.
// [R3] In every response mode a fault drives the alert output low and sets its status flag.
// [R4] An undercurrent fault sets the undercurrent flag, with the response byte in the usual fault layout.
// [R5] The retry count field sets how many restarts are tried before the device gives up.
// [R6] A retry count of zero makes no restart and keeps the output off until the fault is cleared.
// [R7] A retry count of seven retries without limit until disable, loss of bias or another fault.
// [R8] The wait between restarts is the retry time field plus one, times 35 ms.
// [R9] Each average limit is a 16-bit per-phase current in amperes in linear number format.
// [R10] Down-slope sensing averages the off-time samples, leaving out the blanking samples.
// [R11] Up-slope sensing averages the on-time samples, leaving out the blanking samples.
// [R12] An average overcurrent breach sets the overcurrent flag and starts the overcurrent response.
// [R13] An average undercurrent breach sets the undercurrent flag and starts the undercurrent response.
// [R14] In two-phase operation the combined threshold is twice the programmed per-phase limit.
// [R15] The retry attempt count is cleared after a lasting restart or when the output is disabled.
`default_nettype none
package cfr_pkg;
    localparam logic [7:0]  CMD_UC_RESPONSE = 8'he6;
    localparam logic [7:0]  CMD_AVG_OC_LIM  = 8'he7;
    localparam logic [7:0]  CMD_AVG_UC_LIM  = 8'he8;
    localparam logic [7:0]  RST_UC_RESPONSE = 8'h80;
    localparam logic [15:0] RST_AVG_OC_LIM  = 16'h7bff;
    localparam logic [15:0] RST_AVG_UC_LIM  = 16'h0000;
    localparam int          RESP_HI         = 7;
    localparam int          RESP_LO         = 6;
    localparam int          RETRY_HI        = 5;
    localparam int          RETRY_LO        = 3;
    localparam int          RTIME_HI        = 2;
    localparam int          RTIME_LO        = 0;
    localparam logic [1:0]  MODE_RETRY      = 2'h2;
    localparam logic [1:0]  MODE_RESUME     = 2'h3;
    localparam logic [2:0]  RETRY_NONE      = 3'h0;
    localparam logic [2:0]  RETRY_FOREVER   = 3'h7;
    localparam int          LIN_EXP_HI      = 15;
    localparam int          LIN_EXP_LO      = 11;
    localparam int          LIN_MANT_HI     = 10;
    localparam int          SAMPLE_FRAC     = 4;
    localparam int          CLK_HZ          = 25_000_000;
    localparam int          RETRY_UNIT_MS   = 35;
    localparam logic [19:0] RETRY_UNIT_CYC  = 20'(RETRY_UNIT_MS * (CLK_HZ / 1000));

    typedef enum logic [2:0] {ST_RUN, ST_DELAY, ST_HOLD, ST_RESUME, ST_OFF} cfr_state_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  cmd;
        logic [15:0] wdata;
    } cfr_reg_req_t;

    typedef struct packed {
        logic        valid;
        logic        on_time;
        logic        blank;
        logic        window_end;
        logic [15:0] value;
    } cfr_sample_t;
endpackage : cfr_pkg
`default_nettype wire

/* File: logic/cfr_fault_cfg.sv */
`timescale 1ns/10ps
`default_nettype none
module cfr_fault_cfg #(
    parameter logic [19:0] RETRY_UNIT_CYC = cfr_pkg::RETRY_UNIT_CYC
) (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire cfr_pkg::cfr_reg_req_t reg_req,
    output logic [15:0]                reg_rdata,
    output logic                       reg_rvalid,
    output logic                       reg_hit,
    input  wire cfr_pkg::cfr_sample_t  sample,
    input  wire logic                  slope_up,
    input  wire logic                  two_phase,
    input  wire logic                  std_uc_fault,
    input  wire logic                  peak_oc_fault,
    input  wire logic                  other_fault_shutdown,
    input  wire logic                  op_enable,
    input  wire logic                  clear_faults,
    output logic                       output_en,
    output logic                       status_oc,
    output logic                       status_uc,
    output logic                       oc_response_evt,
    output logic                       alert_out_n
);
    typedef struct packed {
        cfr_pkg::cfr_state_t state;
        logic [7:0]          resp;
        logic [15:0]         oc_lim;
        logic [15:0]         uc_lim;
        logic [15:0]         rdata;
        logic                rvalid;
        logic                rhit;
        logic                out_en;
        logic                st_oc;
        logic                st_uc;
        logic                oc_evt;
        logic                alert_n;
        logic                uc_avg_active;
        logic [2:0]          retry_cnt;
        logic [3:0]          units;
        logic [19:0]         tick;
        logic [23:0]         acc_sum;
        logic [7:0]          acc_cnt;
    } cfr_st_t;

    cfr_st_t q;
    cfr_st_t d;

    // Converts a linear-format current to unsigned amperes in sample units.
    function automatic logic [31:0] lin_to_fix(input logic [15:0] v);
        logic signed [4:0] e;
        logic [10:0]       m;
        int                sh;
        e  = v[cfr_pkg::LIN_EXP_HI:cfr_pkg::LIN_EXP_LO];
        m  = v[cfr_pkg::LIN_MANT_HI:0];
        sh = int'(e) + cfr_pkg::SAMPLE_FRAC;
        if (m[cfr_pkg::LIN_MANT_HI]) begin
            return 32'h0;
        end
        if (sh >= 0) begin
            return {21'h0, m} << sh;
        end
        return {21'h0, m} >> (-sh);
    endfunction : lin_to_fix

    logic [1:0]  mode;
    logic [2:0]  retry_lim;
    logic        take;
    logic        win_end;
    logic [47:0] nph;
    logic [47:0] lhs;
    logic [47:0] rhs_oc;
    logic [47:0] rhs_uc;
    logic        avg_oc_hit;
    logic        avg_uc_hit;
    logic        uc_fault;
    logic        unit_end;

    always_comb begin
        mode      = q.resp[cfr_pkg::RESP_HI:cfr_pkg::RESP_LO];
        retry_lim = q.resp[cfr_pkg::RETRY_HI:cfr_pkg::RETRY_LO];
        // [R10] [R11] slope window select
        take      = sample.valid && !sample.blank && (sample.on_time == slope_up);
        win_end   = sample.valid && sample.window_end;
        // Samples carry the combined output current, so only the limit side scales.
        // [R14] doubled combined threshold
        nph       = two_phase ? 48'h2 : 48'h1;
        // [R9] linear limit compare
        lhs       = 48'(q.acc_sum);
        rhs_oc    = 48'(lin_to_fix(q.oc_lim)) * nph * 48'(q.acc_cnt);
        rhs_uc    = 48'(lin_to_fix(q.uc_lim)) * nph * 48'(q.acc_cnt);
        avg_oc_hit = win_end && (q.acc_cnt != 8'h0) && (lhs > rhs_oc);
        avg_uc_hit = win_end && (q.acc_cnt != 8'h0) && (lhs < rhs_uc);
        uc_fault  = std_uc_fault || avg_uc_hit;
        unit_end  = (q.tick == RETRY_UNIT_CYC - 20'h1);
    end

    always_comb begin
        d        = q;
        d.rvalid = 1'b0;
        d.oc_evt = 1'b0;
        if (reg_req.wr) begin
            case (reg_req.cmd)
                cfr_pkg::CMD_UC_RESPONSE: d.resp   = reg_req.wdata[7:0];
                cfr_pkg::CMD_AVG_OC_LIM:  d.oc_lim = reg_req.wdata;
                cfr_pkg::CMD_AVG_UC_LIM:  d.uc_lim = reg_req.wdata;
                default:                  d.resp   = q.resp;
            endcase
        end
        if (reg_req.rd) begin
            d.rvalid = 1'b1;
            d.rhit   = 1'b1;
            case (reg_req.cmd)
                cfr_pkg::CMD_UC_RESPONSE: d.rdata = {8'h00, q.resp};
                cfr_pkg::CMD_AVG_OC_LIM:  d.rdata = q.oc_lim;
                cfr_pkg::CMD_AVG_UC_LIM:  d.rdata = q.uc_lim;
                default: begin
                    d.rdata = 16'h0000;
                    d.rhit  = 1'b0;
                end
            endcase
        end
        if (win_end) begin
            d.acc_sum       = 24'h0;
            d.acc_cnt       = 8'h0;
            d.uc_avg_active = avg_uc_hit;
        end else if (take && q.acc_cnt != 8'hff) begin
            d.acc_sum = q.acc_sum + 24'(sample.value);
            d.acc_cnt = q.acc_cnt + 8'h1;
        end
        // [R12] shared overcurrent path
        d.oc_evt = avg_oc_hit;
        if (clear_faults) begin
            d.st_oc = 1'b0;
            d.st_uc = 1'b0;
        end
        if (avg_oc_hit || peak_oc_fault) begin
            d.st_oc = 1'b1;
        end
        // [R4] [R13] undercurrent flag set
        if (uc_fault) begin
            d.st_uc = 1'b1;
        end
        // [R3] alert follows flags
        d.alert_n = !(d.st_oc || d.st_uc);
        d.tick = unit_end ? 20'h0 : q.tick + 20'h1;
        case (q.state)
            cfr_pkg::ST_RUN: begin
                // [R15] lasting restart clears count
                if (unit_end && q.retry_cnt != 3'h0) begin
                    d.retry_cnt = 3'h0;
                end
                if (q.retry_cnt == 3'h0) begin
                    d.tick = 20'h0;
                end
                if (uc_fault && mode == cfr_pkg::MODE_RETRY) begin
                    // [R1] off then retry
                    d.out_en = 1'b0;
                    d.tick   = 20'h0;
                    d.units  = {1'b0, q.resp[cfr_pkg::RTIME_HI:cfr_pkg::RTIME_LO]} + 4'h1;
                    // [R5] [R6] [R7] retry budget
                    if (retry_lim == cfr_pkg::RETRY_NONE ||
                        (retry_lim != cfr_pkg::RETRY_FOREVER && q.retry_cnt >= retry_lim)) begin
                        d.state = cfr_pkg::ST_HOLD;
                    end else begin
                        d.state = cfr_pkg::ST_DELAY;
                    end
                end else if (uc_fault && mode == cfr_pkg::MODE_RESUME) begin
                    // [R2] off until fault gone
                    d.out_en = 1'b0;
                    d.state  = cfr_pkg::ST_RESUME;
                end
            end
            cfr_pkg::ST_DELAY: begin
                // [R8] retry spacing in 35 ms units
                if (unit_end) begin
                    d.units = q.units - 4'h1;
                    if (q.units == 4'h1) begin
                        d.out_en    = 1'b1;
                        d.retry_cnt = q.retry_cnt + 3'h1;
                        d.tick      = 20'h0;
                        d.state     = cfr_pkg::ST_RUN;
                    end
                end
            end
            cfr_pkg::ST_HOLD: begin
                if (clear_faults) begin
                    d.out_en    = 1'b1;
                    d.retry_cnt = 3'h0;
                    d.state     = cfr_pkg::ST_RUN;
                end
            end
            cfr_pkg::ST_RESUME: begin
                if (!std_uc_fault && !q.uc_avg_active && !avg_uc_hit) begin
                    d.out_en = 1'b1;
                    d.state  = cfr_pkg::ST_RUN;
                end
            end
            cfr_pkg::ST_OFF: begin
                if (op_enable) begin
                    d.out_en = 1'b1;
                    d.state  = cfr_pkg::ST_RUN;
                end
            end
            default: d.state = cfr_pkg::ST_OFF;
        endcase
        if (other_fault_shutdown && q.state != cfr_pkg::ST_OFF) begin
            d.out_en = 1'b0;
            d.state  = cfr_pkg::ST_HOLD;
        end
        if (!op_enable) begin
            // [R15] disable clears count
            d.out_en    = 1'b0;
            d.retry_cnt = 3'h0;
            d.state     = cfr_pkg::ST_OFF;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q        <= '0;
            q.state  <= cfr_pkg::ST_OFF;
            q.resp   <= cfr_pkg::RST_UC_RESPONSE;
            q.oc_lim <= cfr_pkg::RST_AVG_OC_LIM;
            q.uc_lim <= cfr_pkg::RST_AVG_UC_LIM;
            q.alert_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata       = q.rdata;
    assign reg_rvalid      = q.rvalid;
    assign reg_hit         = q.rhit;
    assign output_en       = q.out_en;
    assign status_oc       = q.st_oc;
    assign status_uc       = q.st_uc;
    assign oc_response_evt = q.oc_evt;
    assign alert_out_n     = q.alert_n;

    chk_alert_flags: assert property (@(posedge clk) disable iff (sys_rst) // [R3]
        alert_out_n == !(status_oc || status_uc)) else $error("alert does not follow flags");
    chk_retry_off: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
        (q.state == cfr_pkg::ST_RUN && uc_fault && mode == cfr_pkg::MODE_RETRY)
        |=> !output_en ##0 (q.state != cfr_pkg::ST_RUN)) else $error("retry mode left output on");
    chk_resume_off: assert property (@(posedge clk) disable iff (sys_rst) // [R2]
        (q.state == cfr_pkg::ST_RUN && uc_fault && mode == cfr_pkg::MODE_RESUME && op_enable &&
         !other_fault_shutdown) |=> (q.state == cfr_pkg::ST_RESUME && !output_en))
        else $error("resume mode did not shut off");
    chk_uc_flag: assert property (@(posedge clk) disable iff (sys_rst) // [R13]
        avg_uc_hit |=> status_uc) else $error("average undercurrent not flagged");
    chk_oc_share: assert property (@(posedge clk) disable iff (sys_rst) // [R12]
        avg_oc_hit |=> (status_oc && oc_response_evt)) else $error("average overcurrent lost");
    chk_retry_budget: assert property (@(posedge clk) disable iff (sys_rst) // [R5]
        (q.state == cfr_pkg::ST_RUN && uc_fault && mode == cfr_pkg::MODE_RETRY && op_enable &&
         !other_fault_shutdown && retry_lim != cfr_pkg::RETRY_FOREVER && q.retry_cnt >= retry_lim)
        |=> q.state == cfr_pkg::ST_HOLD) else $error("retry budget overrun");
    chk_hold_stays: assert property (@(posedge clk) disable iff (sys_rst) // [R6]
        (q.state == cfr_pkg::ST_HOLD && !clear_faults && op_enable) |=> $stable(q.state) && !output_en)
        else $error("output restarted without clear");
    chk_forever_retry: assert property (@(posedge clk) disable iff (sys_rst) // [R7]
        (q.state == cfr_pkg::ST_RUN && uc_fault && mode == cfr_pkg::MODE_RETRY && op_enable &&
         !other_fault_shutdown && retry_lim == cfr_pkg::RETRY_FOREVER)
        |=> q.state == cfr_pkg::ST_DELAY) else $error("continuous retry gave up");
    chk_delay_load: assert property (@(posedge clk) disable iff (sys_rst) // [R8]
        (q.state != cfr_pkg::ST_DELAY) ##1 (q.state == cfr_pkg::ST_DELAY) |->
        q.units == {1'b0, $past(q.resp[cfr_pkg::RTIME_HI:cfr_pkg::RTIME_LO])} + 4'h1)
        else $error("retry delay length wrong");
    chk_delay_end: assert property (@(posedge clk) disable iff (sys_rst) // [R8]
        (q.state == cfr_pkg::ST_DELAY && unit_end && q.units == 4'h1 && op_enable &&
         !other_fault_shutdown) |=> (output_en && q.state == cfr_pkg::ST_RUN))
        else $error("retry did not restart on time");
    chk_count_clear: assert property (@(posedge clk) disable iff (sys_rst) // [R15]
        !op_enable |=> (q.retry_cnt == 3'h0 && !output_en)) else $error("retry count not cleared");
endmodule : cfr_fault_cfg
`default_nettype wire

/* File: test/cfr_host.sv */
`timescale 1ns/10ps
`default_nettype none
module cfr_host (
    input  wire logic             clk,
    output var cfr_pkg::cfr_reg_req_t reg_req,
    input  wire logic [15:0]      reg_rdata,
    input  wire logic             reg_rvalid,
    input  wire logic             reg_hit
);
    initial reg_req = '0;

    // A released command and data bus shows the inverse of its last value.
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(posedge clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, cmd: c, wdata: d};
        @(posedge clk);
        reg_req <= '{wr: 1'b0, rd: 1'b0, cmd: ~c, wdata: ~d};
    endtask : wr

    task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic h);
        int n;
        @(posedge clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, cmd: c, wdata: 16'h0000};
        @(posedge clk);
        reg_req <= '{wr: 1'b0, rd: 1'b0, cmd: ~c, wdata: 16'hffff};
        #1;
        for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        // Without the valid strobe the answer is unknown, so the caller's compare trips.
        d = (reg_rvalid === 1'b1) ? reg_rdata : 16'hxxxx;
        h = (reg_rvalid === 1'b1) ? reg_hit : 1'bx;
    endtask : rd
endmodule : cfr_host
`default_nettype wire

/* File: test/test_current_fault_response_config.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin miscompares++; \
    $display("BAD %0t %s", $time, m); end end
module test_current_fault_response_config;
    logic                  clk, sys_rst, slope_up, two_phase, std_uc_fault, peak_oc_fault;
    logic                  other_fault_shutdown, op_enable, clear_faults, evt_seen;
    cfr_pkg::cfr_reg_req_t reg_req;
    cfr_pkg::cfr_sample_t  sample;
    logic [15:0]           reg_rdata, rd_d;
    logic                  reg_rvalid, reg_hit, output_en, status_oc, status_uc;
    logic                  oc_response_evt, alert_out_n, rd_h;
    int                    miscompares = 0, checks = 0, cycles = 0, w;

    cfr_fault_cfg #(.RETRY_UNIT_CYC(20'h14)) u_cfr_fault_cfg (.clk(clk), .sys_rst(sys_rst),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_hit(reg_hit),
        .sample(sample), .slope_up(slope_up), .two_phase(two_phase),
        .std_uc_fault(std_uc_fault), .peak_oc_fault(peak_oc_fault),
        .other_fault_shutdown(other_fault_shutdown), .op_enable(op_enable),
        .clear_faults(clear_faults), .output_en(output_en), .status_oc(status_oc),
        .status_uc(status_uc), .oc_response_evt(oc_response_evt), .alert_out_n(alert_out_n));
    cfr_host u_cfr_host (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .reg_hit(reg_hit));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // The whole run needs about 600 cycles; 20000 means a hang.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic clr();
        @(posedge clk) clear_faults <= 1'b1;
        @(posedge clk) clear_faults <= 1'b0;
        tick(2);
        `CHK(alert_out_n, 1'b1, "alert stays low after clear")
    endtask : clr

    task automatic uc_hit();
        @(posedge clk) std_uc_fault <= 1'b1;
        @(posedge clk) std_uc_fault <= 1'b0;
        tick(1);
    endtask : uc_hit

    task automatic wait_on(input int lim);
        for (w = 0; w < lim && output_en !== 1'b1; w++) tick(1);
    endtask : wait_on

    // One period: a blank sample, two counted ones, one of the other slope, then the end mark.
    // The response event stands for one cycle only, so it is looked at just after each edge.
    task automatic window(input logic [15:0] v, input logic up, input logic [15:0] j);
        @(posedge clk) sample <= '{valid: 1'b1, on_time: up, blank: 1'b1, window_end: 1'b0, value: j};
        repeat (2) @(posedge clk) sample <= '{1'b1, up, 1'b0, 1'b0, v};
        @(posedge clk) sample <= '{1'b1, ~up, 1'b0, 1'b0, j};
        @(posedge clk) sample <= '{1'b1, up, 1'b0, 1'b1, j};
        @(posedge clk) sample <= '{1'b0, up, 1'b0, 1'b0, ~j};
        evt_seen = 1'b0;
        repeat (3) begin
            #1;
            if (oc_response_evt === 1'b1) evt_seen = 1'b1;
            @(posedge clk);
        end
        #1;
    endtask : window

    task automatic t_regs();
        u_cfr_host.rd(8'he6, rd_d, rd_h);
        `CHK(rd_d, 16'h0080, "response reset value")
        `CHK(rd_h, 1'b1, "mapped read not hit")
        u_cfr_host.rd(8'he7, rd_d, rd_h);
        `CHK(rd_d, 16'h7bff, "oc limit reset value")
        u_cfr_host.rd(8'he9, rd_d, rd_h);
        `CHK({rd_h, rd_d}, 17'h00000, "unmapped read")
        u_cfr_host.wr(8'he8, 16'h000a);
        u_cfr_host.wr(8'he7, 16'h000a);
        u_cfr_host.rd(8'he8, rd_d, rd_h);
        `CHK(rd_d, 16'h000a, "uc limit readback")
        $display("test regs done");
    endtask : t_regs

    task automatic t_flag_modes();
        for (int m = 0; m < 2; m++) begin
            u_cfr_host.wr(8'he6, {8'h00, m[1:0], 6'h00});
            uc_hit();
            `CHK({status_uc, status_oc, alert_out_n}, 3'b100, "uc flag or alert wrong")
            `CHK(output_en, 1'b1, "output dropped in flag-only mode")
            clr();
        end
        $display("test flag modes done");
    endtask : t_flag_modes

    task automatic t_resume();
        u_cfr_host.wr(8'he6, 16'h00c0);
        window(16'h0050, 1'b0, 16'hffff);
        `CHK({status_uc, alert_out_n, output_en}, 3'b100, "average uc breach response")
        window(16'h00c8, 1'b0, 16'h0000);
        `CHK(output_en, 1'b1, "no resume after good window")
        clr();
        $display("test resume done");
    endtask : t_resume

    task automatic t_avg_oc();
        @(posedge clk) slope_up <= 1'b1;
        u_cfr_host.wr(8'he8, 16'h0000);
        window(16'h00b0, 1'b1, 16'h0000);
        `CHK({status_oc, status_uc, alert_out_n}, 3'b100, "average oc flags")
        `CHK(evt_seen, 1'b1, "no oc response event")
        clr();
        $display("test average oc done");
    endtask : t_avg_oc

    task automatic t_retry();
        u_cfr_host.wr(8'he6, 16'h0089);
        uc_hit();
        `CHK(output_en, 1'b0, "output not off at once")
        tick(30);
        `CHK(output_en, 1'b0, "restart too early")
        wait_on(20);
        `CHK((w >= 7 && w <= 13), 1'b1, "restart delay not two units")
        uc_hit();
        tick(70);
        `CHK(output_en, 1'b0, "retry budget exceeded")
        clr();
        `CHK(output_en, 1'b1, "hold not left on clear")
        uc_hit();
        wait_on(60);
        tick(25);
        uc_hit();
        wait_on(60);
        `CHK(output_en, 1'b1, "count kept after lasting restart")
        @(posedge clk) op_enable <= 1'b0;
        tick(3);
        @(posedge clk) op_enable <= 1'b1;
        tick(3);
        uc_hit();
        wait_on(60);
        `CHK(output_en, 1'b1, "retry count kept over disable")
        clr();
        $display("test retry done");
    endtask : t_retry

    task automatic t_no_retry_forever();
        u_cfr_host.wr(8'he6, 16'h0080);
        uc_hit();
        tick(80);
        `CHK(output_en, 1'b0, "zero retry restarted")
        clr();
        u_cfr_host.wr(8'he6, 16'h00b8);
        repeat (3) begin
            uc_hit();
            wait_on(40);
            `CHK(output_en, 1'b1, "continuous retry stopped")
        end
        clr();
        $display("test retry limits done");
    endtask : t_no_retry_forever

    // The limit is 10 A per phase; two phases trip only above 20 A of combined current.
    task automatic t_two_phase();
        @(posedge clk) two_phase <= 1'b1;
        window(16'h00b0, 1'b1, 16'h0000);
        `CHK({status_oc, evt_seen}, 2'b00, "two-phase tripped at one-phase limit")
        window(16'h0150, 1'b1, 16'h0000);
        `CHK({status_oc, evt_seen}, 2'b11, "two-phase missed doubled limit")
        clr();
        @(posedge clk) two_phase <= 1'b0;
        $display("test two phase done");
    endtask : t_two_phase

    task automatic t_shared();
        @(posedge clk) peak_oc_fault <= 1'b1;
        @(posedge clk) peak_oc_fault <= 1'b0;
        tick(1);
        `CHK({status_oc, status_uc, alert_out_n}, 3'b100, "peak oc not flagged")
        clr();
        @(posedge clk) other_fault_shutdown <= 1'b1;
        @(posedge clk) other_fault_shutdown <= 1'b0;
        tick(5);
        `CHK(output_en, 1'b0, "other fault did not stop output")
        clr();
        `CHK(output_en, 1'b1, "output not back after clear")
        $display("test shared faults done");
    endtask : t_shared

    initial begin
        {sys_rst, op_enable} = 2'b11;
        {slope_up, two_phase, std_uc_fault, peak_oc_fault} = 4'h0;
        {other_fault_shutdown, clear_faults} = 2'b00;
        sample = '0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        tick(2);
        t_regs();
        t_flag_modes();
        t_resume();
        t_avg_oc();
        t_retry();
        t_no_retry_forever();
        t_two_phase();
        t_shared();
        end_sim();
    end
endmodule : test_current_fault_response_config
`default_nettype wire
